// ==== include/csl_pkg.sv ====
// register map, field layout, reset values and trip levels of the stage/limit bank
// assumes the serial engine presents byte addresses and one-cycle strobes
package csl_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CSL_OFS_MODULE_COUNT = 8'h15;
  localparam logic [7:0] CSL_OFS_LIMITS_CFG = 8'h16;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CSL_BIT_COUNT_LSB = 4;
  localparam int CSL_BIT_PEAK_LSB = 6;
  localparam int CSL_BIT_WARN_LSB = 4;
  localparam int CSL_BIT_FORCE_RST = 2;
  localparam int CSL_BIT_RST_IND = 1;
  localparam int CSL_BIT_THERMAL_A = 0;

  // ------------------------------------------------------------
  // default values after any register reset
  // ------------------------------------------------------------
  localparam logic [3:0] CSL_RST_COUNT = 4'h7;
  localparam logic [1:0] CSL_RST_PEAK = 2'h3;
  localparam logic [1:0] CSL_RST_WARN = 2'h0;
  localparam logic CSL_RST_THERMAL_A = 1'h0;
  localparam logic [7:0] CSL_RST_STAGE_EN = 8'hFF;

  // ------------------------------------------------------------
  // decoded levels
  // ------------------------------------------------------------
  localparam logic [3:0] CSL_COUNT_SAT = 4'h7;
  localparam logic [6:0] CSL_TWARN_83C = 7'h53;
  localparam logic [6:0] CSL_TWARN_94C = 7'h5E;
  localparam logic [6:0] CSL_TWARN_105C = 7'h69;
  localparam logic [6:0] CSL_TWARN_116C = 7'h74;
  localparam logic [11:0] CSL_IPK_2900MA = 12'hB54;
  localparam logic [11:0] CSL_IPK_3400MA = 12'hD48;
  localparam logic [11:0] CSL_IPK_3900MA = 12'hF3C;

  typedef enum logic [1:0] {
    CSL_RUN,
    CSL_SHUT,
    CSL_HALT
  } csl_therm_t;
endpackage

// ==== core/csl_stage_limits.sv ====
// stage-count and limits/reset configuration registers with thermal shutdown re-arm
// assumes the serial engine sits on core_clk; thermal_shutdown comes from analogue
//
// Overview of operation
// [RQ1] count code 0000 gives one stage, each step one more, 0111 and above eight
// [RQ2] with re-arm clear, stay shut down after thermal shutdown until power-on reset
// [RQ3] with re-arm set, restart power-up after thermal shutdown, keeping register values
// [RQ4] reset indicator set on every defaults load; software writes 0 to acknowledge
// [RQ5] writing 1 to force bit reloads defaults; the bit reads zero
// [RQ6] warning code 00/01/10/11 selects 83/94/105/116 degrees C
// [RQ7] peak code 00 and 01 give 2.9 A, 10 gives 3.4 A, 11 gives 3.9 A
// [RQ8] spare bits ignore writes and read zero
`timescale 1ns/100ps
module csl_stage_limits (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port from the serial engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // analogue status
  input wire logic thermal_shutdown,
  // decoded controls
  output logic [7:0] stage_enable,
  output logic [6:0] warn_level_c,
  output logic [11:0] peak_limit_ma,
  output logic converter_off,
  output logic powerup_restart
);
  typedef struct packed {
    logic [3:0] count;
    logic [1:0] peak_current_limit;
    logic [1:0] thermal_warning_threshold;
    logic rst_ind;
    logic thermal_a;
    logic therm_s1;
    logic therm_s2;
    csl_pkg::csl_therm_t therm_st;
    logic [7:0] stage_en;
    logic [6:0] warn_c;
    logic [11:0] ipk_ma;
    logic [7:0] rdata;
    logic off;
    logic restart;
  } csl_state_t;

  csl_state_t q, d;
  logic wr_count, wr_limits, force_rst;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.restart = 1'h0;
    wr_count = reg_wr && (reg_addr == csl_pkg::CSL_OFS_MODULE_COUNT);
    wr_limits = reg_wr && (reg_addr == csl_pkg::CSL_OFS_LIMITS_CFG);
    force_rst = wr_limits && reg_wdata[csl_pkg::CSL_BIT_FORCE_RST];
    // pin is asynchronous; only the second flop feeds the sequencer
    d.therm_s1 = thermal_shutdown;
    d.therm_s2 = q.therm_s1;
    if (force_rst) begin
      // whole write ignored besides the reload; force bit itself is never stored
      d.count = csl_pkg::CSL_RST_COUNT; // [RQ5]
      d.peak_current_limit = csl_pkg::CSL_RST_PEAK; // [RQ5]
      d.thermal_warning_threshold = csl_pkg::CSL_RST_WARN; // [RQ5]
      d.thermal_a = csl_pkg::CSL_RST_THERMAL_A; // [RQ5]
      d.rst_ind = 1'h1; // [RQ4]
    end else begin
      if (wr_count) begin
        d.count = reg_wdata[csl_pkg::CSL_BIT_COUNT_LSB +: 4]; // [RQ8]
      end
      if (wr_limits) begin
        d.peak_current_limit = reg_wdata[csl_pkg::CSL_BIT_PEAK_LSB +: 2];
        d.thermal_warning_threshold = reg_wdata[csl_pkg::CSL_BIT_WARN_LSB +: 2];
        d.thermal_a = reg_wdata[csl_pkg::CSL_BIT_THERMAL_A];
        // only a 0 acknowledges; a written 1 cannot fake a reset
        if (!reg_wdata[csl_pkg::CSL_BIT_RST_IND]) begin
          d.rst_ind = 1'h0; // [RQ4]
        end
      end
    end
    // thermal shutdown sequencing; registers are untouched here
    case (q.therm_st)
      csl_pkg::CSL_RUN: begin
        if (q.therm_s2) begin
          d.therm_st = csl_pkg::CSL_SHUT;
        end
      end
      csl_pkg::CSL_SHUT: begin
        // re-arm is sampled when the overtemperature clears
        if (!q.therm_s2) begin
          if (q.thermal_a) begin
            d.therm_st = csl_pkg::CSL_RUN; // [RQ3]
            d.restart = 1'h1; // [RQ3]
          end else begin
            d.therm_st = csl_pkg::CSL_HALT; // [RQ2]
          end
        end
      end
      default: begin
        // only a power-on reset leaves the latched state
        d.therm_st = csl_pkg::CSL_HALT; // [RQ2]
      end
    endcase
    d.off = (d.therm_st != csl_pkg::CSL_RUN);
    // decode from stored fields; outputs follow a write by two edges
    for (int i = 0; i < 8; i++) begin
      d.stage_en[i] = (q.count >= csl_pkg::CSL_COUNT_SAT) || (q.count >= 4'(i)); // [RQ1]
    end
    case (q.thermal_warning_threshold)
      2'h0: d.warn_c = csl_pkg::CSL_TWARN_83C; // [RQ6]
      2'h1: d.warn_c = csl_pkg::CSL_TWARN_94C; // [RQ6]
      2'h2: d.warn_c = csl_pkg::CSL_TWARN_105C; // [RQ6]
      default: d.warn_c = csl_pkg::CSL_TWARN_116C; // [RQ6]
    endcase
    case (q.peak_current_limit)
      2'h2: d.ipk_ma = csl_pkg::CSL_IPK_3400MA; // [RQ7]
      2'h3: d.ipk_ma = csl_pkg::CSL_IPK_3900MA; // [RQ7]
      default: d.ipk_ma = csl_pkg::CSL_IPK_2900MA; // [RQ7]
    endcase
    if (reg_rd) begin
      if (reg_addr == csl_pkg::CSL_OFS_MODULE_COUNT) begin
        d.rdata = {q.count, 4'h0}; // [RQ8]
      end else if (reg_addr == csl_pkg::CSL_OFS_LIMITS_CFG) begin
        d.rdata = {q.peak_current_limit, q.thermal_warning_threshold, 2'h0, // [RQ5] [RQ8]
          q.rst_ind, q.thermal_a};
      end else begin
        d.rdata = 8'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q <= '0;
      q.count <= csl_pkg::CSL_RST_COUNT;
      q.peak_current_limit <= csl_pkg::CSL_RST_PEAK;
      q.thermal_warning_threshold <= csl_pkg::CSL_RST_WARN;
      q.thermal_a <= csl_pkg::CSL_RST_THERMAL_A;
      q.rst_ind <= 1'h1; // [RQ4]
      q.therm_st <= csl_pkg::CSL_RUN;
      q.stage_en <= csl_pkg::CSL_RST_STAGE_EN;
      q.warn_c <= csl_pkg::CSL_TWARN_83C;
      q.ipk_ma <= csl_pkg::CSL_IPK_3900MA;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign stage_enable = q.stage_en;
  assign warn_level_c = q.warn_c;
  assign peak_limit_ma = q.ipk_ma;
  assign converter_off = q.off;
  assign powerup_restart = q.restart;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // outputs trail the stored fields by one edge, so decode checks look one edge on
  a_stage_count_decode: assert property ( // [RQ1]
    ##1 stage_enable == ((q.count >= 4'h7) ? 8'hFF : 8'((9'h002 << $past(q.count)) - 9'h001))
    || $past(q.count) != q.count)
    else $error("stage enable does not match count");
  a_count_stored: assert property ( // [RQ1]
    reg_wr && reg_addr == 8'h15
    |=> q.count == $past(reg_wdata[7:4]))
    else $error("stage count write not stored");
  a_halt_sticks: assert property ( // [RQ2]
    q.therm_st == csl_pkg::CSL_HALT |=> q.therm_st == csl_pkg::CSL_HALT && converter_off)
    else $error("latched shutdown released");
  a_shut_is_off: assert property ( // [RQ2]
    q.therm_st == csl_pkg::CSL_SHUT |-> converter_off)
    else $error("converter running during shutdown");
  a_unarmed_latch: assert property ( // [RQ2]
    q.therm_st == csl_pkg::CSL_SHUT && !q.therm_s2 && !q.thermal_a |=> converter_off)
    else $error("shutdown without re-arm did not latch");
  a_armed_restart: assert property ( // [RQ3]
    q.therm_st == csl_pkg::CSL_SHUT && !q.therm_s2 && q.thermal_a |=> powerup_restart)
    else $error("re-arm restart pulse missing");
  a_restart_keeps: assert property ( // [RQ3]
    powerup_restart && !$past(reg_wr) |-> $stable(q.count) && $stable(q.peak_current_limit))
    else $error("restart disturbed registers");
  a_restart_is_on: assert property ( // [RQ3]
    powerup_restart |-> !converter_off ##1 !powerup_restart)
    else $error("restart pulse without converter on");
  a_force_sets_ind: assert property ( // [RQ4]
    reg_wr && reg_addr == 8'h16 && reg_wdata[2]
    |=> q.rst_ind && q.count == 4'h7 && q.thermal_warning_threshold == 2'h0)
    else $error("force reset did not load defaults");
  a_ind_ack: assert property ( // [RQ4]
    reg_wr && reg_addr == 8'h16 && !reg_wdata[2] && !reg_wdata[1] |=> !q.rst_ind)
    else $error("reset indicator not acknowledged");
  a_force_reads_zero: assert property ( // [RQ5]
    reg_rd && reg_addr == 8'h16 |=> reg_rdata[3:2] == 2'b00)
    else $error("force or spare bit read nonzero");
  a_warn_map: assert property ( // [RQ6]
    q.thermal_warning_threshold == 2'h2
    |=> warn_level_c == 7'h69)
    else $error("warning level wrong");
  a_peak_map: assert property ( // [RQ7]
    q.peak_current_limit[1] == 1'h0 |=> peak_limit_ma == 12'hB54)
    else $error("peak limit wrong for low codes");
  a_spare_zero: assert property ( // [RQ8]
    reg_rd && reg_addr == 8'h15 |=> reg_rdata[3:0] == 4'h0)
    else $error("spare bits read nonzero");
  a_stray_write: assert property ( // [RQ8]
    reg_wr && reg_addr != 8'h15 && reg_addr != 8'h16
    |=> $stable(q.count) && $stable(q.thermal_warning_threshold))
    else $error("write to unused address changed a field");

  // covers for the main scenarios
  c_force_reset: cover property (reg_wr && reg_addr == 8'h16 && reg_wdata[2]);
  c_armed_restart: cover property (powerup_restart);
  c_latched_off: cover property (q.therm_st == csl_pkg::CSL_HALT);
  c_ack_then_reset: cover property (!q.rst_ind ##1 q.rst_ind);
  c_single_stage: cover property (stage_enable == 8'h01);
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for the stage-count and limits register bank
// assumes the bank is driven straight from the bench at 10 MHz, no serial engine
`timescale 1ns/100ps
module tb_top;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic thermal_shutdown = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, stage_enable;
  logic [6:0] warn_level_c;
  logic [11:0] peak_limit_ma;
  logic converter_off, powerup_restart;
  int n_fail = 0;
  int check_count = 0;
  logic [6:0] wl [4] = '{csl_pkg::CSL_TWARN_83C, csl_pkg::CSL_TWARN_94C,
    csl_pkg::CSL_TWARN_105C, csl_pkg::CSL_TWARN_116C};
  logic [11:0] pk [4] = '{csl_pkg::CSL_IPK_2900MA, csl_pkg::CSL_IPK_2900MA,
    csl_pkg::CSL_IPK_3400MA, csl_pkg::CSL_IPK_3900MA};

  always #50 core_clk = ~core_clk;

  csl_stage_limits dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .thermal_shutdown(thermal_shutdown), .stage_enable(stage_enable),
    .warn_level_c(warn_level_c), .peak_limit_ma(peak_limit_ma),
    .converter_off(converter_off), .powerup_restart(powerup_restart));

  // ------------------------------------------------------------
  // bench tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // every task starts and ends just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // strobe dropped for one cycle so back-to-back calls never retoggle in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk({4'h0, reg_rdata}, {4'h0, exp});
    tick(1);
  endtask
  task automatic defaults_seen;
    rd(8'h15, 8'h70);
    rd(8'h16, 8'hC2);
    chk({4'h0, stage_enable}, 12'h0FF);
    chk({5'h00, warn_level_c}, {5'h00, csl_pkg::CSL_TWARN_83C});
    chk(peak_limit_ma, csl_pkg::CSL_IPK_3900MA);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    tick(5);
    sys_rst = 1'b0;
    defaults_seen();
    for (int c = 0; c < 16; c++) begin
      wr(8'h15, {c[3:0], 4'hF});
      tick(1);
      chk({4'h0, stage_enable}, 12'((c > 6) ? 12'h0FF : (2 << c) - 1));
      rd(8'h15, {c[3:0], 4'h0});
    end
    wr(8'h16, 8'h00);
    rd(8'h16, 8'h00);
    // indicator written 1 must stay clear, spare bit written 1 reads zero
    for (int c = 0; c < 16; c++) begin
      wr(8'h16, {c[3:0], 4'hA});
      tick(1);
      chk({5'h00, warn_level_c}, {5'h00, wl[c % 4]});
      chk(peak_limit_ma, pk[c / 4]);
      rd(8'h16, {c[3:0], 4'h0});
    end
    wr(8'h16, 8'h34);
    tick(1);
    defaults_seen();
    wr(8'h17, 8'hFF);
    rd(8'h17, 8'h00);
    // latched off without re-arm
    thermal_shutdown = 1'b1;
    tick(5);
    chk({11'h000, converter_off}, 12'h001);
    thermal_shutdown = 1'b0;
    for (int i = 0; i < 10; i++) begin
      tick(1);
      chk({10'h000, converter_off, powerup_restart}, 12'h002);
    end
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    defaults_seen();
    // re-arm keeps programmed values across the restart
    wr(8'h15, 8'h30);
    wr(8'h16, 8'h91);
    thermal_shutdown = 1'b1;
    tick(5);
    chk({11'h000, converter_off}, 12'h001);
    thermal_shutdown = 1'b0;
    for (int i = 0; i < 12 && powerup_restart !== 1'b1; i++) tick(1);
    chk({10'h000, converter_off, powerup_restart}, 12'h001);
    tick(1);
    chk({11'h000, powerup_restart}, 12'h000);
    rd(8'h15, 8'h30);
    rd(8'h16, 8'h91);
    chk({4'h0, stage_enable}, 12'h00F);
    stop_test();
  end
endmodule
